/* src/adfc_regs.svh */
// register map, field positions, reset values and timing counts
// assumes a 32-bit avalon-mm slave with byte addresses, word aligned
`ifndef ADFC_REGS_SVH
`define ADFC_REGS_SVH
`define ADFC_OFF_CTRL     8'h00
`define ADFC_OFF_LIMIT    8'h04
`define ADFC_OFF_OVERHEAD 8'h08
`define ADFC_OFF_CMODE    8'h0c
`define ADFC_OFF_OCSET    8'h10
`define ADFC_OFF_BOOST    8'h14
`define ADFC_OFF_LOWTH    8'h18
`define ADFC_OFF_HIGHTH   8'h1c
`define ADFC_OFF_LCOFF    8'h20
`define ADFC_OFF_LCON     8'h24
`define ADFC_OFF_LCDEB    8'h28
`define ADFC_OFF_GKLO     8'h2c
`define ADFC_OFF_GKHI     8'h30
`define ADFC_OFF_GKDEB    8'h34
`define ADFC_OFF_STATUS   8'h38
`define ADFC_OFF_MASK     8'h3c
`define ADFC_OFF_HOOK     8'h40
`define ADFC_OFF_TRACK    8'h44
`define ADFC_OFF_FILT     8'h48
// ctrl fields
`define ADFC_CTRL_DISC    3
`define ADFC_CTRL_CAL     4
// status / mask bit positions
`define ADFC_ST_LOOP      0
`define ADFC_ST_GKEY      1
`define ADFC_ST_REGION    2
`define ADFC_ST_CAL       3
// current limit: units of 0.125 mA, 18 mA base, 0.875 mA step
`define ADFC_LIM_BASE     9'h090
`define ADFC_LIM_STEP     9'h007
// source impedance in ohms
`define ADFC_OHM_HIGH     10'h280
`define ADFC_OHM_LOW      10'h140
// calibration cycle length in clocks
`define ADFC_CAL_CYCLES   9'h100
`define ADFC_RST_WORD     16'h0000
`endif

/* src/adfc_pkg.sv */
// types shared by the adaptive dc feed control block
// assumes adfc_regs.svh supplies the numeric constants
package adfc_pkg;
  typedef enum logic [2:0] {
    ADFC_OPEN      = 3'h0,
    ADFC_FWD       = 3'h1,
    ADFC_FWD_OHT   = 3'h2,
    ADFC_TIP_OPEN  = 3'h3,
    ADFC_RINGING   = 3'h4,
    ADFC_REV       = 3'h5,
    ADFC_REV_OHT   = 3'h6,
    ADFC_RING_OPEN = 3'h7
  } adfc_feed_t;

  // gray along high-z -> low-z -> current limit
  typedef enum logic [1:0] {
    ADFC_RG_HIGHZ = 2'b00,
    ADFC_RG_LOWZ  = 2'b01,
    ADFC_RG_LIMIT = 2'b11
  } adfc_region_t;

  typedef struct packed {
    logic        on;
    logic [15:0] cnt;
  } adfc_det_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] loopV;
    logic [15:0] batV;
    logic [15:0] loopI;
    logic [15:0] longI;
  } adfc_sample_t;

  typedef struct packed {
    adfc_feed_t  state;
    logic        tipHiZ;
    logic        ringHiZ;
    logic        lowZ;
    logic        constCurrent;
    logic [9:0]  ohms;
    logic [15:0] target;
    logic [8:0]  limit;
    logic        calActive;
  } adfc_feed_out_t;

  typedef struct packed {
    adfc_feed_t     feed;
    logic           discrete;
    logic           cal;
    logic [8:0]     calCnt;
    logic [4:0]     limitCode;
    logic [15:0]    ov;
    logic [15:0]    cm;
    logic [15:0]    oc;
    logic [15:0]    boost;
    logic [15:0]    lowTh;
    logic [15:0]    highTh;
    logic [15:0]    lcOff;
    logic [15:0]    lcOn;
    logic [15:0]    lcDeb;
    logic [15:0]    gkLo;
    logic [15:0]    gkHi;
    logic [15:0]    gkDeb;
    logic [7:0]     filt;
    logic [3:0]     status;
    logic [3:0]     mask;
    adfc_region_t   region;
    logic [15:0]    loopFilt;
    logic [15:0]    longFilt;
    adfc_det_t      lc;
    adfc_det_t      gk;
    logic [15:0]    tracked;
    logic           ack;
    logic [31:0]    readData;
    adfc_feed_out_t out;
  } adfc_state_t;
endpackage : adfc_pkg

/* src/adfc_top.sv */
// adaptive dc feed control: region selection, tracked open voltage,
// hook and ground key detection, ground start, calibration trigger
// assumes monitor samples arrive as one-cycle valid pulses on clock
//
// Behaviour
// RULE1 - limit code 0..31 maps 18 mA to 45 mA in 0.875 mA steps
// RULE2 - software encodes voltages with the ratio-to-1.005 V formula
// RULE3 - integrated feed 640 ohm then 320 ohm; discrete 320 ohm always
// RULE4 - falling voltage at low threshold: go 320 ohm, add boost
// RULE5 - low impedance kept until loop current hits limit, then constant
// RULE6 - rising voltage at high threshold: back to high-z, drop boost
// RULE7 - zero boost removes only the boost, impedance still switches
// RULE8 - tracked voltage is setpoint, or battery minus overheads if short
// RULE9 - thresholds are signed offsets from the tracked voltage
// RULE10 - software keeps low below, high above, high under overhead-1V
// RULE11 - codes 011/111 float tip or ring lead, other lead active
// RULE12 - ground start uses the same switch thresholds on active lead
// RULE13 - ground key: filtered long current, two thresholds, debounce
// RULE14 - ground key moves tip-open to forward, ring-open to reverse
// RULE15 - feed codes: open 000, forward 001, reverse 101
// RULE16 - loop closure: filtered loop current, two thresholds, debounce
// RULE17 - calibrate bit set by software, cleared when cycle completes
// RULE18 - after reset the feed is open; one calibration suffices
// RULE19 - comparisons and tracking update on each new monitor sample
`timescale 1ns/1ps
`include "adfc_regs.svh"

module adfc_top (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic [7:0]            avsAddress,
  input  wire logic                  avsRead,
  input  wire logic                  avsWrite,
  input  wire logic [31:0]           avsWriteData,
  output logic      [31:0]           avsReadData,
  output logic                       avsWaitRequest,
  input  wire adfc_pkg::adfc_sample_t sample,
  output adfc_pkg::adfc_feed_out_t   feedOut,
  output logic                       irq
);

  localparam int CAL_WAIT = 300;

  adfc_pkg::adfc_state_t s;
  adfc_pkg::adfc_state_t n;
  logic                  wrEn;
  logic                  feedActive;
  logic signed [16:0]    lowLevel;
  logic signed [16:0]    highLevel;
  logic signed [16:0]    vLoop;
  logic [15:0]           trackNext;
  logic [15:0]           w16;
  logic [3:0]            w4;

  //////////////////////////////////////////////////////////////////////
  // helpers

  // battery tracking of the open circuit voltage, floors at zero
  function automatic logic [15:0] adfc_track(
    input logic [15:0] oc,
    input logic [15:0] ov,
    input logic [15:0] cm,
    input logic [15:0] bat
  );
    logic [16:0] head;
    logic [16:0] sum;
    logic [16:0] diff;
    head = {1'b0, ov} + {1'b0, cm};
    sum  = head + {1'b0, oc};
    diff = {1'b0, bat} - head;
    if ({1'b0, bat} >= sum)
      adfc_track = oc; // RULE8
    else if ({1'b0, bat} > head)
      adfc_track = diff[15:0]; // RULE8
    else
      adfc_track = `ADFC_RST_WORD;
  endfunction : adfc_track

  // signed offset from the tracked voltage
  function automatic logic signed [16:0] adfc_level(
    input logic [15:0] base,
    input logic [15:0] off
  );
    adfc_level = $signed({1'b0, base}) + $signed({off[15], off}); // RULE9
  endfunction : adfc_level

  // first order low pass, coefficient as a shift
  function automatic logic [15:0] adfc_filter(
    input logic [15:0] f,
    input logic [15:0] x,
    input logic [3:0]  sh
  );
    logic signed [16:0] d;
    logic signed [16:0] r;
    d = $signed({1'b0, x}) - $signed({1'b0, f});
    r = $signed({1'b0, f}) + (d >>> sh);
    adfc_filter = r[15:0];
  endfunction : adfc_filter

  // hysteresis detector: set at or above setTh, clear below clrTh,
  // each change needs the condition for deb+1 consecutive samples
  function automatic adfc_pkg::adfc_det_t adfc_debounce(
    input adfc_pkg::adfc_det_t d,
    input logic [15:0]         f,
    input logic [15:0]         setTh,
    input logic [15:0]         clrTh,
    input logic [15:0]         deb
  );
    logic cond;
    adfc_debounce = d;
    cond = d.on ? (f < clrTh) : (f >= setTh);
    if (!cond) begin
      adfc_debounce.cnt = `ADFC_RST_WORD;
    end else if (d.cnt >= deb) begin
      adfc_debounce.on  = !d.on;
      adfc_debounce.cnt = `ADFC_RST_WORD;
    end else begin
      adfc_debounce.cnt = d.cnt + 16'h0001;
    end
  endfunction : adfc_debounce

  //////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, the write lands on the edge after it,
  // where waitrequest is sampled low, so write data is taken exactly once
  assign avsWaitRequest = (avsRead || avsWrite) && !s.ack;
  assign wrEn           = avsWrite && s.ack;
  assign avsReadData    = s.readData;
  assign feedOut        = s.out;
  assign irq            = |(s.status & s.mask);
  assign w16            = avsWriteData[15:0];
  assign w4             = avsWriteData[3:0];

  // region logic only runs while a lead is actually driven
  assign feedActive = (s.feed != adfc_pkg::ADFC_OPEN) &&
                      (s.feed != adfc_pkg::ADFC_RINGING);
  assign trackNext  = adfc_track(s.oc, s.ov, s.cm, sample.batV);
  assign lowLevel   = adfc_level(trackNext, s.lowTh);
  assign highLevel  = adfc_level(trackNext, s.highTh);
  assign vLoop      = $signed({1'b0, sample.loopV});

  //////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    n     = s;
    n.ack = (avsRead || avsWrite) && !s.ack;

    // read data latched in the wait cycle, stands at the answer edge
    if (avsRead && !s.ack) begin
      case (avsAddress)
        `ADFC_OFF_CTRL:     n.readData = {27'h0000000, s.cal, s.discrete,
                                          s.feed};
        `ADFC_OFF_LIMIT:    n.readData = {27'h0000000, s.limitCode};
        `ADFC_OFF_OVERHEAD: n.readData = {16'h0000, s.ov};
        `ADFC_OFF_CMODE:    n.readData = {16'h0000, s.cm};
        `ADFC_OFF_OCSET:    n.readData = {16'h0000, s.oc};
        `ADFC_OFF_BOOST:    n.readData = {16'h0000, s.boost};
        `ADFC_OFF_LOWTH:    n.readData = {16'h0000, s.lowTh};
        `ADFC_OFF_HIGHTH:   n.readData = {16'h0000, s.highTh};
        `ADFC_OFF_LCOFF:    n.readData = {16'h0000, s.lcOff};
        `ADFC_OFF_LCON:     n.readData = {16'h0000, s.lcOn};
        `ADFC_OFF_LCDEB:    n.readData = {16'h0000, s.lcDeb};
        `ADFC_OFF_GKLO:     n.readData = {16'h0000, s.gkLo};
        `ADFC_OFF_GKHI:     n.readData = {16'h0000, s.gkHi};
        `ADFC_OFF_GKDEB:    n.readData = {16'h0000, s.gkDeb};
        `ADFC_OFF_STATUS:   n.readData = {28'h0000000, s.status};
        `ADFC_OFF_MASK:     n.readData = {28'h0000000, s.mask};
        `ADFC_OFF_HOOK:     n.readData = {28'h0000000, s.region,
                                          s.gk.on, s.lc.on};
        `ADFC_OFF_TRACK:    n.readData = {s.out.target, s.tracked};
        `ADFC_OFF_FILT:     n.readData = {24'h000000, s.filt};
        default:            n.readData = 32'h00000000;
      endcase
    end

    // software writes; unmapped addresses are dropped
    if (wrEn) begin
      case (avsAddress)
        `ADFC_OFF_CTRL: begin
          n.feed     = adfc_pkg::adfc_feed_t'(avsWriteData[2:0]); // RULE11
          n.discrete = avsWriteData[`ADFC_CTRL_DISC];
          // a running calibration cannot be cancelled by software
          if (avsWriteData[`ADFC_CTRL_CAL] && !s.cal) begin
            n.cal    = 1'b1; // RULE17
            n.calCnt = `ADFC_CAL_CYCLES;
          end
        end
        `ADFC_OFF_LIMIT:    n.limitCode = avsWriteData[4:0];
        `ADFC_OFF_OVERHEAD: n.ov        = w16;
        `ADFC_OFF_CMODE:    n.cm        = w16;
        `ADFC_OFF_OCSET:    n.oc        = w16;
        `ADFC_OFF_BOOST:    n.boost     = w16;
        `ADFC_OFF_LOWTH:    n.lowTh     = w16;
        `ADFC_OFF_HIGHTH:   n.highTh    = w16;
        `ADFC_OFF_LCOFF:    n.lcOff     = w16;
        `ADFC_OFF_LCON:     n.lcOn      = w16;
        `ADFC_OFF_LCDEB:    n.lcDeb     = w16;
        `ADFC_OFF_GKLO:     n.gkLo      = w16;
        `ADFC_OFF_GKHI:     n.gkHi      = w16;
        `ADFC_OFF_GKDEB:    n.gkDeb     = w16;
        `ADFC_OFF_STATUS:   n.status    = s.status & ~w4;
        `ADFC_OFF_MASK:     n.mask      = w4;
        `ADFC_OFF_FILT:     n.filt      = avsWriteData[7:0];
        default: begin
        end
      endcase
    end

    // calibration countdown, bit drops by itself at the end
    if (s.cal) begin
      if (s.calCnt <= 9'h001) begin
        n.cal                 = 1'b0; // RULE17
        n.calCnt              = 9'h000;
        n.status[`ADFC_ST_CAL] = 1'b1;
      end else begin
        n.calCnt = s.calCnt - 9'h001;
      end
    end

    // per-sample work: tracking, filters, detectors, region
    if (sample.valid) begin
      n.tracked  = trackNext; // RULE19
      n.loopFilt = adfc_filter(s.loopFilt, sample.loopI, s.filt[3:0]);
      n.longFilt = adfc_filter(s.longFilt, sample.longI, s.filt[7:4]);
      n.lc = adfc_debounce(s.lc, n.loopFilt, s.lcOff, s.lcOn,
                           s.lcDeb); // RULE16
      n.gk = adfc_debounce(s.gk, n.longFilt, s.gkHi, s.gkLo,
                           s.gkDeb); // RULE13
      if (n.lc.on && !s.lc.on)
        n.status[`ADFC_ST_LOOP] = 1'b1; // RULE16
      if (n.gk.on && !s.gk.on) begin
        n.status[`ADFC_ST_GKEY] = 1'b1; // RULE13
        // ground start: key event returns the open lead to service
        if (n.feed == adfc_pkg::ADFC_TIP_OPEN)
          n.feed = adfc_pkg::ADFC_FWD; // RULE14
        else if (n.feed == adfc_pkg::ADFC_RING_OPEN)
          n.feed = adfc_pkg::ADFC_REV; // RULE14
      end

      // same thresholds for loop start and ground start active lead
      if (feedActive) begin
        case (s.region)
          adfc_pkg::ADFC_RG_HIGHZ: begin
            if (vLoop <= lowLevel)
              n.region = adfc_pkg::ADFC_RG_LOWZ; // RULE4 RULE12
          end
          adfc_pkg::ADFC_RG_LOWZ: begin
            if (vLoop >= highLevel)
              n.region = adfc_pkg::ADFC_RG_HIGHZ; // RULE6 RULE12
            else if ({7'h00, sample.loopI[15:7]} >= 16'h0000 &&
                     sample.loopI >= {7'h00, s.out.limit})
              n.region = adfc_pkg::ADFC_RG_LIMIT; // RULE5
          end
          adfc_pkg::ADFC_RG_LIMIT: begin
            if (vLoop >= highLevel)
              n.region = adfc_pkg::ADFC_RG_HIGHZ; // RULE6
            else if (sample.loopI < {7'h00, s.out.limit})
              n.region = adfc_pkg::ADFC_RG_LOWZ; // RULE5
          end
          default: n.region = adfc_pkg::ADFC_RG_HIGHZ;
        endcase
      end
    end
    if (!feedActive)
      n.region = adfc_pkg::ADFC_RG_HIGHZ;
    if (n.region != s.region)
      n.status[`ADFC_ST_REGION] = 1'b1;

    // feed outputs derived from the next state so they match it
    n.out.state     = n.feed;
    n.out.tipHiZ    = (n.feed == adfc_pkg::ADFC_TIP_OPEN) ||
                      (n.feed == adfc_pkg::ADFC_OPEN); // RULE11
    n.out.ringHiZ   = (n.feed == adfc_pkg::ADFC_RING_OPEN) ||
                      (n.feed == adfc_pkg::ADFC_OPEN); // RULE11
    n.out.lowZ      = n.region != adfc_pkg::ADFC_RG_HIGHZ;
    n.out.constCurrent = n.region == adfc_pkg::ADFC_RG_LIMIT; // RULE5
    // discrete stage is 320 ohm on both sides of the transition
    n.out.ohms = (n.discrete || n.out.lowZ) ? `ADFC_OHM_LOW
                                            : `ADFC_OHM_HIGH; // RULE3 RULE7
    // zero boost simply adds nothing; the impedance still switches
    n.out.target = n.out.lowZ ? n.tracked + n.boost
                              : n.tracked; // RULE4 RULE6 RULE7
    n.out.limit  = `ADFC_LIM_BASE +
                   `ADFC_LIM_STEP * {4'h0, n.limitCode}; // RULE1
    n.out.calActive = n.cal;
  end

  //////////////////////////////////////////////////////////////////////
  // state register; reset leaves the line open
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s          <= '0;
      s.feed     <= adfc_pkg::ADFC_OPEN; // RULE15 RULE18
      s.region   <= adfc_pkg::ADFC_RG_HIGHZ;
      s.out.ohms <= `ADFC_OHM_HIGH;
      s.out.limit <= `ADFC_LIM_BASE;
      s.out.tipHiZ  <= 1'b1;
      s.out.ringHiZ <= 1'b1;
    end else begin
      s <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks

  sequence sLowCross;
    sample.valid && feedActive &&
      s.region == adfc_pkg::ADFC_RG_HIGHZ && vLoop <= lowLevel;
  endsequence

  sequence sHighCross;
    sample.valid && feedActive &&
      s.region != adfc_pkg::ADFC_RG_HIGHZ && vLoop >= highLevel;
  endsequence

  sequence sCalStart;
    wrEn && avsAddress == `ADFC_OFF_CTRL &&
      avsWriteData[`ADFC_CTRL_CAL] && !s.cal;
  endsequence

  AST_LOW_SWITCH: assert property (@(posedge clock) disable iff (!rst_n) // RULE4
    sLowCross |=> s.out.lowZ && s.out.ohms == `ADFC_OHM_LOW &&
      s.out.target == s.tracked + s.boost)
    else $error("low threshold crossing did not switch region");

  AST_HIGH_SWITCH: assert property (@(posedge clock) disable iff (!rst_n) // RULE6
    sHighCross |=> !s.out.lowZ && s.out.target == s.tracked)
    else $error("high threshold crossing did not restore high-z");

  AST_IMPEDANCE: assert property (@(posedge clock) disable iff (!rst_n) // RULE3
    s.out.ohms == ((s.discrete || s.out.lowZ) ? `ADFC_OHM_LOW
                                              : `ADFC_OHM_HIGH))
    else $error("source impedance wrong for region");

  AST_LIMIT_MAP: assert property (@(posedge clock) disable iff (!rst_n) // RULE1
    s.out.limit == `ADFC_LIM_BASE + `ADFC_LIM_STEP * {4'h0, s.limitCode})
    else $error("current limit mapping wrong");

  AST_TRACK: assert property (@(posedge clock) disable iff (!rst_n) // RULE8
    sample.valid |=> s.tracked == $past(trackNext))
    else $error("tracked voltage not updated on sample");

  AST_CONST_CURRENT: assert property (@(posedge clock) disable iff (!rst_n) // RULE5
    sample.valid && feedActive && s.region == adfc_pkg::ADFC_RG_LOWZ &&
      vLoop < highLevel && sample.loopI >= {7'h00, s.out.limit}
      |=> s.out.constCurrent)
    else $error("limit reached without constant current");

  AST_GK_RETURN: assert property (@(posedge clock) disable iff (!rst_n) // RULE14
    $rose(s.gk.on) && $past(s.feed) == adfc_pkg::ADFC_TIP_OPEN &&
      !$past(wrEn) |-> s.feed == adfc_pkg::ADFC_FWD)
    else $error("ground key did not return tip-open to forward");

  AST_GK_FLAG: assert property (@(posedge clock) disable iff (!rst_n) // RULE13
    $rose(s.gk.on) |-> s.status[`ADFC_ST_GKEY])
    else $error("ground key event not flagged");

  AST_LC_FLAG: assert property (@(posedge clock) disable iff (!rst_n) // RULE16
    $rose(s.lc.on) |-> s.status[`ADFC_ST_LOOP])
    else $error("loop closure event not flagged");

  AST_CAL_CLEAR: assert property (@(posedge clock) disable iff (!rst_n) // RULE17
    sCalStart |=> s.cal [*8] ##[1:CAL_WAIT] !s.cal)
    else $error("calibrate bit did not clear in time");

  AST_RESET_OPEN: assert property (@(posedge clock) // RULE18
    $past(!rst_n) && rst_n |-> s.out.state == adfc_pkg::ADFC_OPEN)
    else $error("feed not open after reset");

  AST_IRQ: assert property (@(posedge clock) disable iff (!rst_n)
    irq == |(s.status & s.mask))
    else $error("interrupt does not follow masked status");

  AST_WAIT_ONE: assert property (@(posedge clock) disable iff (!rst_n)
    (avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
    else $error("waitrequest held beyond one cycle");

endmodule : adfc_top

/* test/adfc_loop_model.sv */
// subscriber loop as seen through the monitor converter
// assumes the bench sets line levels and pulses take once per sample
`timescale 1ns/1ps
module adfc_loop_model (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              take,
  input  wire logic [63:0]       line,
  output adfc_pkg::adfc_sample_t sample
);
  ////////////////////////////////////////
  // one valid pulse per sample; fields scrambled in between so
  // the block cannot lean on stale converter values
  always @(posedge clock) begin
    if (!rst_n) begin
      sample <= '0;
    end else if (take) begin
      sample <= {1'b1, line};
    end else begin
      sample <= {1'b0, ~sample[63:0]};
    end
  end
endmodule : adfc_loop_model

/* test/test_adaptive_dc_feed_control.sv */
// self-checking bench for the adaptive dc feed control block
// assumes adfc_loop_model feeds samples and avalon reads wait one cycle
`timescale 1ns/1ps
`include "adfc_regs.svh"
module test_adaptive_dc_feed_control;
  logic                     clock = 1'b0;
  logic                     rst_n = 1'b0;
  logic [7:0]               avsAddress = 8'h00;
  logic                     avsRead = 1'b0;
  logic                     avsWrite = 1'b0;
  logic [31:0]              avsWriteData = 32'h0;
  logic [31:0]              avsReadData;
  logic                     avsWaitRequest;
  logic                     take = 1'b0;
  logic [63:0]              line = 64'h0;
  adfc_pkg::adfc_sample_t   sample;
  adfc_pkg::adfc_feed_out_t feedOut;
  logic                     irq;
  int                       n_fail = 0;
  int                       cmp_count = 0;
  int                       oc, ov, cm, lowTh, highTh, bat, trk, lim, n, k;
  logic [31:0]              rd;

  always #2.5 clock = ~clock;

  adfc_top u_adfc_top (.clock(clock), .rst_n(rst_n),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .sample(sample),
    .feedOut(feedOut), .irq(irq));
  adfc_loop_model u_adfc_loop_model (.clock(clock), .rst_n(rst_n),
    .take(take), .line(line), .sample(sample));

  ////////////////////////////////////////
  // verdict and comparison helpers
  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  ////////////////////////////////////////
  // avalon master: request held until waitrequest is sampled low
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWriteData <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 20);
    rd = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    if (n >= 20) begin
      n_fail++;
      print_verdict();
    end
    @(negedge clock); // let register updates land before sampling
  endtask : bus

  // one monitor sample: loop voltage, loop current, long current
  task send(input int v, input int i, input int l);
    @(posedge clock);
    line <= {v[15:0], bat[15:0], i[15:0], l[15:0]};
    take <= 1'b1;
    @(posedge clock);
    take <= 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask : send

  // voltage to ram code, integer form of the rounding formula
  function int enc(input int volts);
    int r;
    r = (volts * 1000 + 502) / 1005;
    return 2 * ((r * 512 + 4) / 5);
  endfunction : enc

  ////////////////////////////////////////
  // full adaptive cycle: tracking, both crossings, limit, irq
  task region(input int disc, input int boost, input int m, input int b);
    int hiOhm;
    hiOhm = disc ? 320 : 640;
    bat = b;
    trk = (b >= oc + ov + cm) ? oc : b - ov - cm;
    bus(1, `ADFC_OFF_BOOST, boost);
    bus(1, `ADFC_OFF_MASK, m);
    bus(1, `ADFC_OFF_CTRL, 1 | disc << 3);
    send(trk + lowTh + 1, 0, 0);
    bus(0, `ADFC_OFF_TRACK, 0);
    chk("tracked", rd[15:0], trk);
    chk("edge lowZ", feedOut.lowZ, 0);
    chk("high ohms", feedOut.ohms, hiOhm);
    send(trk + lowTh, 0, 0);
    chk("lowZ", feedOut.lowZ, 1);
    chk("low ohms", feedOut.ohms, 320);
    chk("boost", feedOut.target, trk + boost);
    chk("irq", irq, m != 0);
    bus(1, `ADFC_OFF_STATUS, 32'hf);
    chk("irq clr", irq, 0);
    send(trk + lowTh, lim, 0);
    chk("const I", feedOut.constCurrent, 1);
    send(trk + highTh, 0, 0);
    chk("back", {feedOut.lowZ, feedOut.ohms}, {1'b0, hiOhm[9:0]});
    chk("drop", feedOut.target, trk);
  endtask : region

  ////////////////////////////////////////
  // main sequence
  initial begin
    rd = $urandom(32'h55fc);
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    chk("reset", feedOut.state, adfc_pkg::ADFC_OPEN);
    chk("reset ohms", feedOut.ohms, 640);
    // detector thresholds first: zero thresholds would latch both on
    bus(1, `ADFC_OFF_GKLO, 100);
    bus(1, `ADFC_OFF_GKHI, 300);
    bus(1, `ADFC_OFF_LCOFF, 200);
    bus(1, `ADFC_OFF_LCON, 100);
    bus(1, `ADFC_OFF_LCDEB, 1);
    for (k = 0; k < 3; k++) begin
      n = (k == 0) ? 0 : (k == 1) ? 31 : $urandom_range(0, 31);
      lim = 144 + 7 * n;
      bus(1, `ADFC_OFF_LIMIT, n);
      send(0, 0, 0);
      chk("limit", feedOut.limit, lim);
    end
    oc = enc(48);
    ov = enc(4);
    cm = enc(3);
    lowTh = -enc(7);
    highTh = enc(2);
    bus(1, `ADFC_OFF_OCSET, oc);
    bus(1, `ADFC_OFF_OVERHEAD, ov);
    bus(1, `ADFC_OFF_CMODE, cm);
    bus(1, `ADFC_OFF_LOWTH, lowTh & 32'hffff);
    bus(1, `ADFC_OFF_HIGHTH, highTh);
    region(0, enc(6), 4, enc(56));
    region(0, 0, 0, enc(56));
    region(1, enc(6), 4, 8000 + $urandom_range(0, 3000));
    // ground start on each lead, released by a ground key
    for (k = 0; k < 2; k++) begin
      bus(1, `ADFC_OFF_CTRL, k ? 7 : 3);
      send(trk, 0, 0);
      chk("open lead", {feedOut.tipHiZ, feedOut.ringHiZ}, 2 - k);
      send(trk + lowTh, 0, 0);
      chk("gs lowZ", feedOut.lowZ, 1);
      send(trk + highTh, 0, 300);
      chk("gs state", feedOut.state, k ? 5 : 1);
      bus(0, `ADFC_OFF_HOOK, 0);
      chk("gkey", rd[1], 1);
      send(trk, 0, 0);
    end
    // loop closure needs two samples over threshold with debounce 1
    for (k = 0; k < 4; k++) begin
      send(trk, k < 2 ? 50 : 200, 0);
      bus(0, `ADFC_OFF_HOOK, 0);
      chk("loop", rd[0], k == 3);
    end
    bus(1, `ADFC_OFF_CTRL, 32'h10);
    chk("cal on", feedOut.calActive, 1);
    k = 0;
    while (feedOut.calActive !== 1'b0 && k < 400) begin
      @(negedge clock);
      k++;
    end
    if (k >= 400) begin
      n_fail++;
      print_verdict();
    end
    chk("cal cycles", k, `ADFC_CAL_CYCLES);
    bus(0, `ADFC_OFF_CTRL, 0);
    chk("cal self clear", rd[4], 0);
    bus(0, `ADFC_OFF_STATUS, 0);
    chk("cal done", rd[3], 1);
    bus(0, 8'h80, 0);
    chk("unmapped", rd, 0);
    print_verdict();
  end
endmodule : test_adaptive_dc_feed_control
